// ===== shared/txdr_pkg.sv
// constants and types of the transmit descriptor ring engine
// shared by the design and by the verification side; no logic here
package txdr_pkg;

  // register byte offsets on the wishbone slave
  localparam logic [7:0] TXDR_OFS_BASE_LO = 8'h00;
  localparam logic [7:0] TXDR_OFS_BASE_HI = 8'h04;
  localparam logic [7:0] TXDR_OFS_LEN = 8'h08;
  localparam logic [7:0] TXDR_OFS_HEAD = 8'h0c;
  localparam logic [7:0] TXDR_OFS_TAIL = 8'h10;
  localparam logic [7:0] TXDR_OFS_QCTL = 8'h14;
  localparam logic [7:0] TXDR_OFS_DELAY = 8'h18;
  localparam logic [7:0] TXDR_OFS_STAT = 8'h1c;

  // reset values
  localparam logic [31:0] TXDR_RST_REG = 32'h0000_0000;

  // tx_queue_control fields
  localparam int TXDR_QCTL_PTH_LSB = 0;
  localparam int TXDR_QCTL_WTH_LSB = 8;
  localparam int TXDR_QCTL_EN_BIT = 31;

  // descriptor layout (16 bytes)
  localparam int TXDR_DESC_BYTES = 16;
  localparam int TXDR_DESC_SHIFT = 4;
  localparam int TXDR_D_LEN_LSB = 64;
  localparam int TXDR_D_STA_LSB = 96;
  localparam int TXDR_D_CMD_LSB = 88;
  localparam int TXDR_D_HDR_LSB = 104;
  localparam int TXDR_D_MSS_LSB = 112;
  localparam int TXDR_CMD_EOP = 0;
  localparam int TXDR_CMD_TSE = 2;
  localparam int TXDR_CMD_RS = 3;
  localparam int TXDR_CMD_CTX = 4;
  localparam int TXDR_CMD_IDE = 7;
  localparam logic [7:0] TXDR_STA_DONE = 8'h01;

  // fetch shaping: descriptors per cache line
  localparam int TXDR_CL_DESCS = 4;

  // delay timer: unit of one count and the clock period
  localparam int TXDR_TIMER_UNIT_NS = 1024;
  localparam int TXDR_CLK_PERIOD_PS = 4000;
  localparam int TXDR_TICK_CYCLES = (TXDR_TIMER_UNIT_NS * 1000) / TXDR_CLK_PERIOD_PS;

  typedef enum logic [2:0] {
    TXDR_IDLE = 3'b000,
    TXDR_REQ = 3'b001,
    TXDR_RX = 3'b010,
    TXDR_DONE = 3'b011,
    TXDR_FLUSH = 3'b100
  } txdr_state_t;

endpackage

// ===== hdl/txdr_engine.sv
// transmit descriptor ring engine: fetch, data dma, head update, write back
// assumes one 250 MHz clock, in-order completions and a classic wishbone master
`timescale 1ns/1ps
`default_nettype none

module txdr_engine
  import txdr_pkg::*;
#(
  parameter int QDEPTH = 8,
  parameter int TICK_CYCLES = TXDR_TICK_CYCLES
) (
  input wire logic core_clk,
  input wire logic sys_rst,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [7:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  output logic desc_rd_valid,
  input wire logic desc_rd_ready,
  output logic [63:0] desc_rd_addr,
  output logic [15:0] desc_rd_count,
  input wire logic desc_cpl_valid,
  input wire logic [127:0] desc_cpl_data,
  output logic buf_rd_valid,
  input wire logic buf_rd_ready,
  output logic [63:0] buf_rd_addr,
  output logic [15:0] buf_rd_len,
  input wire logic buf_cpl_valid,
  input wire logic [31:0] buf_cpl_data,
  input wire logic buf_cpl_last,
  output logic tx_data_valid,
  output logic [31:0] tx_data,
  output logic tx_seg_boundary,
  output logic [7:0] tx_seg_hdr_len,
  output logic [15:0] tx_seg_mss,
  output logic tx_pkt_ready,
  output logic tx_pkt_tse,
  output logic desc_wb_valid,
  input wire logic desc_wb_ready,
  output logic [63:0] desc_wb_addr,
  output logic [15:0] desc_wb_count,
  output logic desc_wb_status_only,
  output logic [7:0] desc_wb_status,
  output logic tx_wb_event
);

  localparam int QAW = $clog2(QDEPTH);

  // ---------------------------------------------------------------
  // registers
  // ---------------------------------------------------------------
  logic [31:0] base_lo;
  logic [31:0] base_hi;
  logic [31:0] ring_len;
  logic [15:0] head;
  logic [15:0] tail;
  logic [31:0] qctl;
  logic [15:0] delay_val;
  logic [15:0] fetch_ptr;
  logic [QAW:0] q_wr;
  logic [QAW:0] q_rd;
  logic [127:0] q_mem [QDEPTH];
  logic [15:0] fetch_left;
  txdr_state_t state;
  logic [127:0] cur;
  logic [15:0] wb_pend;
  logic [15:0] wb_first;
  logic timer_run;
  logic [15:0] timer_cnt;
  logic [15:0] tick_cnt;
  logic tick;
  logic [15:0] pay_cnt;
  logic hdr_seen;
  logic [7:0] ctx_hdr_len;
  logic [15:0] ctx_mss;

  wire bus_req = wb_cyc_i & wb_stb_i & ~wb_ack_o;
  wire bus_wr = bus_req & wb_we_i;
  wire q_en = qctl[TXDR_QCTL_EN_BIT];
  wire [7:0] pthresh = qctl[TXDR_QCTL_PTH_LSB +: 8];
  wire [7:0] wthresh = qctl[TXDR_QCTL_WTH_LSB +: 8];
  // base ignores its low four bits
  wire [63:0] ring_base = {base_hi, base_lo[31:4], 4'h0};
  wire [15:0] ring_n = ring_len[19:4];
  wire [QAW:0] occ = q_wr - q_rd;
  wire [15:0] q_free = 16'(QDEPTH) - 16'(occ);

  function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] nv,
                                        input logic [3:0] sel);
    logic [31:0] r;
    r = old;
    for (int i = 0; i < 4; i++) begin
      if (sel[i]) begin
        r[i*8 +: 8] = nv[i*8 +: 8];
      end
    end
    return r;
  endfunction

  function automatic logic [15:0] ring_next(input logic [15:0] idx, input logic [15:0] n,
                                            input logic [15:0] len);
    logic [16:0] s;
    s = {1'b0, idx} + {1'b0, n};
    if (s >= {1'b0, len}) begin
      s = s - {1'b0, len};
    end
    return s[15:0];
  endfunction

  function automatic logic [63:0] slot_addr(input logic [63:0] base, input logic [15:0] idx);
    return base + {44'h0, idx, 4'h0};
  endfunction

  // ---------------------------------------------------------------
  // wishbone slave
  // ---------------------------------------------------------------
  // answer one cycle after the request, ack held one cycle; unmapped reads return zero
  always_ff @(posedge core_clk or posedge sys_rst) begin
    if (sys_rst) begin
      wb_ack_o <= 1'b0;
      wb_dat_o <= TXDR_RST_REG;
    end else begin
      wb_ack_o <= bus_req;
      if (bus_req && !wb_we_i) begin
        case (wb_adr_i)
          TXDR_OFS_BASE_LO: wb_dat_o <= base_lo;
          TXDR_OFS_BASE_HI: wb_dat_o <= base_hi;
          TXDR_OFS_LEN: wb_dat_o <= ring_len;
          TXDR_OFS_HEAD: wb_dat_o <= {16'h0, head};
          TXDR_OFS_TAIL: wb_dat_o <= {16'h0, tail};
          TXDR_OFS_QCTL: wb_dat_o <= qctl;
          TXDR_OFS_DELAY: wb_dat_o <= {16'h0, delay_val};
          TXDR_OFS_STAT: wb_dat_o <= {13'h0, state, 16'(occ)};
          default: wb_dat_o <= TXDR_RST_REG;
        endcase
      end
    end
  end

  always_ff @(posedge core_clk or posedge sys_rst) begin
    if (sys_rst) begin
      base_lo <= TXDR_RST_REG;
      base_hi <= TXDR_RST_REG;
      ring_len <= TXDR_RST_REG;
      tail <= TXDR_RST_REG[15:0];
      qctl <= TXDR_RST_REG;
      delay_val <= TXDR_RST_REG[15:0];
    end else if (bus_wr) begin
      case (wb_adr_i)
        TXDR_OFS_BASE_LO: base_lo <= merge(base_lo, wb_dat_i, wb_sel_i);
        TXDR_OFS_BASE_HI: base_hi <= merge(base_hi, wb_dat_i, wb_sel_i);
        TXDR_OFS_LEN: ring_len <= merge(ring_len, wb_dat_i, wb_sel_i);
        TXDR_OFS_TAIL: tail <= 16'(merge({16'h0, tail}, wb_dat_i, wb_sel_i));
        TXDR_OFS_QCTL: qctl <= merge(qctl, wb_dat_i, wb_sel_i);
        TXDR_OFS_DELAY: delay_val <= 16'(merge({16'h0, delay_val}, wb_dat_i, wb_sel_i));
        default: ;
      endcase
    end
  end

  // ---------------------------------------------------------------
  // descriptor fetch
  // ---------------------------------------------------------------
  // one read in flight; it never crosses the ring end or the tail
  logic [15:0] avail;
  logic [15:0] fetch_n;
  logic [15:0] to_line;
  always_comb begin
    avail = (tail >= fetch_ptr) ? (tail - fetch_ptr) : (ring_n - fetch_ptr);
    fetch_n = (avail < q_free) ? avail : q_free;
    to_line = 16'(TXDR_CL_DESCS) - (fetch_ptr & 16'(TXDR_CL_DESCS - 1));
    if (to_line != 16'(TXDR_CL_DESCS)) begin
      fetch_n = (fetch_n < to_line) ? fetch_n : to_line;
    end else if (fetch_n >= 16'(TXDR_CL_DESCS)) begin
      fetch_n = fetch_n & ~16'(TXDR_CL_DESCS - 1);
    end
  end

  // fetch at once when the queue is empty, else when below the prefetch threshold
  wire fetch_go = q_en && !desc_rd_valid && fetch_left == 16'h0 && fetch_n != 16'h0 &&
                  (occ == '0 || 16'(occ) < {8'h0, pthresh});
  wire sw_head_wr = bus_wr && wb_adr_i == TXDR_OFS_HEAD && !q_en;

  always_ff @(posedge core_clk or posedge sys_rst) begin
    if (sys_rst) begin
      desc_rd_valid <= 1'b0;
      desc_rd_addr <= 64'h0;
      desc_rd_count <= 16'h0;
      fetch_ptr <= 16'h0;
      fetch_left <= 16'h0;
      q_wr <= '0;
    end else if (sw_head_wr) begin
      fetch_ptr <= wb_dat_i[15:0];
      q_wr <= q_rd;
    end else begin
      if (fetch_go) begin
        desc_rd_valid <= 1'b1;
        desc_rd_addr <= slot_addr(ring_base, fetch_ptr);
        desc_rd_count <= fetch_n;
      end else if (desc_rd_valid && desc_rd_ready) begin
        desc_rd_valid <= 1'b0;
        fetch_left <= desc_rd_count;
        fetch_ptr <= ring_next(fetch_ptr, desc_rd_count, ring_n);
      end
      if (desc_cpl_valid && fetch_left != 16'h0) begin
        q_wr <= q_wr + 1'b1;
        fetch_left <= fetch_left - 16'h1;
      end
    end
  end

  always_ff @(posedge core_clk) begin
    if (desc_cpl_valid && fetch_left != 16'h0) begin
      q_mem[q_wr[QAW-1:0]] <= desc_cpl_data;
    end
  end

  // ---------------------------------------------------------------
  // delay timer
  // ---------------------------------------------------------------
  always_ff @(posedge core_clk or posedge sys_rst) begin
    if (sys_rst) begin
      tick_cnt <= 16'h0;
      tick <= 1'b0;
    end else begin
      tick <= tick_cnt == 16'(TICK_CYCLES - 1);
      tick_cnt <= (tick_cnt == 16'(TICK_CYCLES - 1)) ? 16'h0 : tick_cnt + 16'h1;
    end
  end

  wire [7:0] cmd = cur[TXDR_D_CMD_LSB +: 8];
  wire timer_hit = timer_run && timer_cnt == 16'h0;

  // ---------------------------------------------------------------
  // data dma, head update and write back
  // ---------------------------------------------------------------
  always_ff @(posedge core_clk or posedge sys_rst) begin
    if (sys_rst) begin
      state <= TXDR_IDLE;
      cur <= 128'h0;
      q_rd <= '0;
      head <= 16'h0;
      buf_rd_valid <= 1'b0;
      buf_rd_addr <= 64'h0;
      buf_rd_len <= 16'h0;
      tx_pkt_ready <= 1'b0;
      tx_pkt_tse <= 1'b0;
      desc_wb_valid <= 1'b0;
      desc_wb_addr <= 64'h0;
      desc_wb_count <= 16'h0;
      desc_wb_status_only <= 1'b0;
      desc_wb_status <= 8'h0;
      tx_wb_event <= 1'b0;
      wb_pend <= 16'h0;
      wb_first <= 16'h0;
      timer_run <= 1'b0;
      timer_cnt <= 16'h0;
      ctx_hdr_len <= 8'h0;
      ctx_mss <= 16'h0;
    end else begin
      tx_pkt_ready <= 1'b0;
      tx_wb_event <= 1'b0;
      if (desc_wb_valid && desc_wb_ready) begin
        desc_wb_valid <= 1'b0;
      end
      if (timer_run && tick && timer_cnt != 16'h0) begin
        timer_cnt <= timer_cnt - 16'h1;
      end
      if (sw_head_wr) begin
        head <= wb_dat_i[15:0];
        state <= TXDR_IDLE;
      end else begin
        case (state)
          TXDR_IDLE: begin
            if (timer_hit && !desc_wb_valid) begin
              state <= TXDR_FLUSH;
            end else if (occ != '0) begin
              cur <= q_mem[q_rd[QAW-1:0]];
              state <= TXDR_REQ;
            end
          end
          TXDR_REQ: begin
            if (cmd[TXDR_CMD_CTX]) begin
              // context persists until another context descriptor arrives
              ctx_hdr_len <= cur[TXDR_D_HDR_LSB +: 8];
              ctx_mss <= cur[TXDR_D_MSS_LSB +: 16];
              state <= TXDR_DONE;
            end else if (!buf_rd_valid) begin
              buf_rd_valid <= 1'b1;
              buf_rd_addr <= cur[63:0];
              buf_rd_len <= cur[TXDR_D_LEN_LSB +: 16];
            end else if (buf_rd_ready) begin
              buf_rd_valid <= 1'b0;
              state <= TXDR_RX;
            end
          end
          TXDR_RX: begin
            if (buf_cpl_valid && buf_cpl_last) begin
              state <= TXDR_DONE;
            end
          end
          TXDR_DONE: begin
            // waits for a free write-back slot so no completion is dropped
            if (!desc_wb_valid) begin
              q_rd <= q_rd + 1'b1;
              head <= ring_next(head, 16'h1, ring_n);
              state <= TXDR_IDLE;
              if (!cmd[TXDR_CMD_CTX] && cmd[TXDR_CMD_EOP]) begin
                tx_pkt_ready <= 1'b1;
                tx_pkt_tse <= cmd[TXDR_CMD_TSE];
              end
              if (wthresh == 8'h0 && !cmd[TXDR_CMD_IDE]) begin
                if (cmd[TXDR_CMD_RS]) begin
                  desc_wb_valid <= 1'b1;
                  desc_wb_addr <= slot_addr(ring_base, head) + 64'(TXDR_D_STA_LSB / 8);
                  desc_wb_count <= 16'h1;
                  desc_wb_status_only <= 1'b1;
                  desc_wb_status <= TXDR_STA_DONE;
                  tx_wb_event <= 1'b1;
                end
              end else begin
                if (wb_pend == 16'h0) begin
                  wb_first <= head;
                end
                if (wthresh != 8'h0 && wb_pend + 16'h1 >= {8'h0, wthresh}) begin
                  desc_wb_valid <= 1'b1;
                  desc_wb_addr <= slot_addr(ring_base, (wb_pend == 16'h0) ? head : wb_first);
                  desc_wb_count <= wb_pend + 16'h1;
                  desc_wb_status_only <= 1'b0;
                  desc_wb_status <= TXDR_STA_DONE;
                  tx_wb_event <= 1'b1;
                  wb_pend <= 16'h0;
                end else begin
                  wb_pend <= wb_pend + 16'h1;
                end
                if (cmd[TXDR_CMD_IDE] && cmd[TXDR_CMD_RS] && !timer_run) begin
                  timer_run <= 1'b1;
                  timer_cnt <= delay_val;
                end
              end
            end
          end
          TXDR_FLUSH: begin
            // timer expiry writes out whatever has accumulated
            timer_run <= 1'b0;
            tx_wb_event <= 1'b1;
            wb_pend <= 16'h0;
            if (wb_pend != 16'h0) begin
              desc_wb_valid <= 1'b1;
              desc_wb_addr <= slot_addr(ring_base, wb_first);
              desc_wb_count <= wb_pend;
              desc_wb_status_only <= 1'b0;
              desc_wb_status <= TXDR_STA_DONE;
            end
            state <= TXDR_IDLE;
          end
          default: state <= TXDR_IDLE;
        endcase
      end
    end
  end

  // ---------------------------------------------------------------
  // data stream and segmentation marks
  // ---------------------------------------------------------------
  // the first buffer of a segmented packet is the prototype header; payload
  // is counted in words, so mss should be a multiple of four bytes
  wire in_payload = state == TXDR_RX && cmd[TXDR_CMD_TSE] && hdr_seen;
  always_ff @(posedge core_clk or posedge sys_rst) begin
    if (sys_rst) begin
      tx_data_valid <= 1'b0;
      tx_data <= 32'h0;
      tx_seg_boundary <= 1'b0;
      tx_seg_hdr_len <= 8'h0;
      tx_seg_mss <= 16'h0;
      pay_cnt <= 16'h0;
      hdr_seen <= 1'b0;
    end else begin
      tx_data_valid <= state == TXDR_RX && buf_cpl_valid;
      tx_data <= buf_cpl_data;
      tx_seg_boundary <= 1'b0;
      tx_seg_hdr_len <= ctx_hdr_len;
      tx_seg_mss <= ctx_mss;
      if (state == TXDR_RX && buf_cpl_valid && buf_cpl_last && cmd[TXDR_CMD_TSE]) begin
        hdr_seen <= !cmd[TXDR_CMD_EOP];
      end
      if (in_payload && buf_cpl_valid) begin
        if (pay_cnt + 16'h4 >= ctx_mss) begin
          tx_seg_boundary <= 1'b1;
          pay_cnt <= 16'h0;
        end else begin
          pay_cnt <= pay_cnt + 16'h4;
        end
      end
      if (tx_pkt_ready) begin
        pay_cnt <= 16'h0;
      end
    end
  end

endmodule

`default_nettype wire

// ===== testbench/txdr_monitor.sv
// checker of the ring engine's host-side handshakes
// bound into txdr_engine; sees only its ports
`timescale 1ns/1ps
`default_nettype none
module txdr_monitor
  import txdr_pkg::*;
#(
  parameter int QDEPTH = 8
) (
  input wire logic core_clk,
  input wire logic sys_rst,
  input wire logic desc_rd_valid,
  input wire logic desc_rd_ready,
  input wire logic [63:0] desc_rd_addr,
  input wire logic [15:0] desc_rd_count,
  input wire logic buf_cpl_valid,
  input wire logic [31:0] buf_cpl_data,
  input wire logic buf_cpl_last,
  input wire logic tx_data_valid,
  input wire logic [31:0] tx_data,
  input wire logic tx_pkt_ready,
  input wire logic desc_wb_valid,
  input wire logic desc_wb_ready,
  input wire logic [63:0] desc_wb_addr,
  input wire logic [15:0] desc_wb_count,
  input wire logic desc_wb_status_only,
  input wire logic [7:0] desc_wb_status
);
  // --------------------------------
  // helper counts
  // --------------------------------
  // a packet may only be announced once its last word has arrived
  logic [15:0] last_n;
  logic [15:0] pkt_n;
  always_ff @(posedge core_clk or posedge sys_rst) begin
    if (sys_rst) begin
      last_n <= '0;
    end else if (buf_cpl_valid && buf_cpl_last) begin
      last_n <= last_n + 16'h1;
    end
  end
  always_ff @(posedge core_clk or posedge sys_rst) begin
    if (sys_rst) begin
      pkt_n <= '0;
    end else if (tx_pkt_ready) begin
      pkt_n <= pkt_n + 16'h1;
    end
  end
  // --------------------------------
  // properties
  // --------------------------------
  default clocking cb @(posedge core_clk);
  endclocking
  default disable iff (sys_rst);
  sequence rd_stall;
    desc_rd_valid && !desc_rd_ready;
  endsequence
  sequence wb_stall;
    desc_wb_valid && !desc_wb_ready;
  endsequence
  rd_hold_a: assert property (rd_stall |=> desc_rd_valid && $stable(desc_rd_addr) &&
    $stable(desc_rd_count)) else $error("descriptor read changed before accept");
  rd_align_a: assert property (desc_rd_valid |-> desc_rd_addr[3:0] == 4'h0)
    else $error("descriptor read address not on a 16 byte boundary");
  rd_count_a: assert property (desc_rd_valid |-> desc_rd_count != 16'h0 && desc_rd_count <= QDEPTH)
    else $error("descriptor read count outside queue depth");
  data_pass_a: assert property (buf_cpl_valid |=> tx_data_valid && tx_data == $past(buf_cpl_data))
    else $error("buffer word not passed on next cycle");
  pkt_whole_a: assert property (tx_pkt_ready |-> pkt_n < last_n)
    else $error("packet announced before its last word");
  sta_only_a: assert property (desc_wb_valid && desc_wb_status_only |->
    desc_wb_status == TXDR_STA_DONE && desc_wb_addr[3:0] == 4'hc) else $error("bad status byte write");
  full_wb_a: assert property (desc_wb_valid && !desc_wb_status_only |->
    desc_wb_addr[3:0] == 4'h0 && desc_wb_count != 16'h0) else $error("bad full write back");
  wb_hold_a: assert property (wb_stall |=> desc_wb_valid && $stable(desc_wb_addr) &&
    $stable(desc_wb_count)) else $error("write back changed before accept");
endmodule
bind txdr_engine txdr_monitor #(.QDEPTH(QDEPTH)) u_mon (.*);
`default_nettype wire

// ===== testbench/txdr_host_model.sv
// host memory model: answers descriptor, buffer and write-back requests
// assumes the engine keeps one request of each kind outstanding
`timescale 1ns/1ps
`default_nettype none
module txdr_host_model
  import txdr_pkg::*;
(
  input wire logic core_clk,
  input wire logic sys_rst,
  input wire logic slow,
  input wire logic [7:0] cmd,
  input wire logic desc_rd_valid,
  output logic desc_rd_ready,
  input wire logic [63:0] desc_rd_addr,
  input wire logic [15:0] desc_rd_count,
  output logic desc_cpl_valid,
  output logic [127:0] desc_cpl_data,
  input wire logic buf_rd_valid,
  output logic buf_rd_ready,
  input wire logic [15:0] buf_rd_len,
  output logic buf_cpl_valid,
  output logic [31:0] buf_cpl_data,
  output logic buf_cpl_last,
  input wire logic desc_wb_valid,
  output logic desc_wb_ready,
  output logic [63:0] rd_end
);
  // slow mode accepts requests only one cycle in four; completions still come every cycle
  logic [1:0] ph;
  logic go;
  logic [15:0] d_left;
  logic [15:0] b_left;
  logic [63:0] d_addr;
  assign go = !slow || ph == 2'd0;
  always_ff @(posedge core_clk or posedge sys_rst) begin
    if (sys_rst) begin
      ph <= '0;
      d_left <= '0;
      b_left <= '0;
      d_addr <= '0;
      rd_end <= '0;
      desc_rd_ready <= 1'b0;
      buf_rd_ready <= 1'b0;
      desc_wb_ready <= 1'b0;
      desc_cpl_valid <= 1'b0;
      desc_cpl_data <= '0;
      buf_cpl_valid <= 1'b0;
      buf_cpl_data <= '0;
      buf_cpl_last <= 1'b0;
    end else begin
      ph <= ph + 2'd1;
      desc_rd_ready <= desc_rd_valid && !desc_rd_ready && go;
      buf_rd_ready <= buf_rd_valid && !buf_rd_ready && go;
      desc_wb_ready <= desc_wb_valid && !desc_wb_ready && go;
      if (desc_rd_valid && desc_rd_ready) begin
        d_left <= desc_rd_count;
        d_addr <= desc_rd_addr;
        rd_end <= desc_rd_addr + {desc_rd_count, 4'h0};
      end else if (d_left != 16'h0) begin
        d_left <= d_left - 16'h1;
        d_addr <= d_addr + 64'h10;
      end
      desc_cpl_valid <= d_left != 16'h0;
      // ring slots hold ready descriptors whose contents never change while owned;
      // top word is read only by context descriptors: mss 4, header length 8
      desc_cpl_data <= (d_left != 16'h0) ? {32'h0004_0800, cmd, 8'h00, 16'h0008, d_addr} : ~desc_cpl_data;
      if (buf_rd_valid && buf_rd_ready) begin
        b_left <= buf_rd_len >> 2;
      end else if (b_left != 16'h0) begin
        b_left <= b_left - 16'h1;
      end
      buf_cpl_valid <= b_left != 16'h0;
      buf_cpl_last <= b_left == 16'h1;
      buf_cpl_data <= (b_left != 16'h0) ? {16'h5a5a, b_left} : ~buf_cpl_data;
    end
  end
endmodule
`default_nettype wire

// ===== testbench/tb.sv
// self-checking bench: register access over wishbone, ring traffic via the host model
// assumes the engine answers each wishbone request within a few cycles
`timescale 1ns/1ps
`default_nettype none
module tb;
  import txdr_pkg::*;
  localparam logic [63:0] BASE = 64'h0000_0001_0000_1000;
  logic core_clk = 1'b0;
  logic sys_rst;
  logic wb_cyc_i = 1'b0, wb_stb_i = 1'b0, wb_we_i = 1'b0, wb_ack_o, slow = 1'b0;
  logic [7:0] wb_adr_i = 8'h00, cmd = 8'h09, tx_seg_hdr_len, desc_wb_status;
  logic [3:0] wb_sel_i = 4'hf;
  logic [31:0] wb_dat_i = 32'h0, wb_dat_o, buf_cpl_data, tx_data, q;
  logic desc_rd_valid, desc_rd_ready, desc_cpl_valid, buf_rd_valid, buf_rd_ready, buf_cpl_valid;
  logic buf_cpl_last, tx_data_valid, tx_seg_boundary, tx_pkt_ready, tx_pkt_tse, tx_wb_event;
  logic desc_wb_valid, desc_wb_ready, desc_wb_status_only;
  logic [63:0] desc_rd_addr, buf_rd_addr, desc_wb_addr, rd_end, rd_first, wb_last, ba;
  logic [15:0] desc_rd_count, buf_rd_len, desc_wb_count, tx_seg_mss;
  logic [127:0] desc_cpl_data;
  int failures = 0, cmp_count = 0, pkt_n = 0, so_n = 0, full_n = 0, ev_n = 0, rd_n = 0, e0;
  int sb_n = 0, tse = 0;
  always #2 core_clk = ~core_clk;
  txdr_engine #(.TICK_CYCLES(4)) dut (.*);
  txdr_host_model host (.*);
  // --------------------------------
  // traffic tallies
  // --------------------------------
  always @(posedge core_clk) begin
    if (tx_pkt_ready === 1'b1) pkt_n <= pkt_n + 1;
    if (tx_pkt_ready === 1'b1) tse <= int'(tx_pkt_tse);
    if (tx_seg_boundary === 1'b1) sb_n <= sb_n + 1;
    if (buf_rd_valid === 1'b1 && buf_rd_ready === 1'b1) ba <= buf_rd_addr;
    if (tx_wb_event === 1'b1) ev_n <= ev_n + 1;
    if (desc_rd_valid === 1'b1 && desc_rd_ready === 1'b1) begin
      rd_n <= rd_n + 1;
      if (rd_n == 0) rd_first <= desc_rd_addr;
    end
    if (desc_wb_valid === 1'b1 && desc_wb_ready === 1'b1) begin
      wb_last <= desc_wb_addr;
      if (desc_wb_status_only === 1'b1) so_n <= so_n + 1;
      else full_n <= full_n + int'(desc_wb_count);
    end
  end
  // --------------------------------
  // tasks
  // --------------------------------
  task automatic summarize();
    $display("comparisons %0d mismatches %0d", cmp_count, failures);
    if (failures == 0 && cmp_count > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask
  task automatic check(input string nm, input logic [63:0] exp, input logic [63:0] got);
    cmp_count++;
    if (got !== exp) begin
      failures++;
      $display("CHECK FAILED %s expected %h seen %h", nm, exp, got);
    end
  endtask
  // classic cycle: hold until ack is sampled, take data at that edge
  task automatic wb(input logic we, input logic [7:0] a, input logic [31:0] d);
    int n;
    n = 0;
    wb_cyc_i <= 1'b1;
    wb_stb_i <= 1'b1;
    wb_we_i <= we;
    wb_adr_i <= a;
    wb_dat_i <= d;
    @(posedge core_clk);
    while (wb_ack_o !== 1'b1) begin
      n++;
      if (n > 50) begin
        failures++;
        summarize();
      end
      @(posedge core_clk);
    end
    q = wb_dat_o;
    wb_cyc_i <= 1'b0;
    wb_stb_i <= 1'b0;
    @(posedge core_clk);
  endtask
  task automatic rd(input string nm, input logic [7:0] a, input logic [31:0] exp);
    wb(1'b0, a, 32'h0);
    check(nm, {32'h0, exp}, {32'h0, q});
  endtask
  task automatic wait_head(input logic [31:0] h);
    for (int i = 0; i < 100; i++) begin
      wb(1'b0, TXDR_OFS_HEAD, 32'h0);
      if (q === h) break;
    end
    check("head", {32'h0, h}, {32'h0, q});
    if (q !== h) summarize();
  endtask
  task automatic wait_cnt(ref int c, input int e);
    for (int i = 0; i < 400 && c < e; i++) @(posedge core_clk);
    if (c < e) begin
      failures++;
      $display("CHECK FAILED wait_count expected %0d seen %0d", e, c);
      summarize();
    end
  endtask
  // --------------------------------
  // main sequence
  // --------------------------------
  initial begin
    sys_rst = 1'b1;
    repeat (16) @(posedge core_clk);
    sys_rst <= 1'b0;
    @(posedge core_clk);
    for (int a = 0; a < 36; a += 4) rd("reset_value", 8'(a), 32'h0);
    wb(1'b1, 8'h20, 32'hffff_ffff);
    rd("unmapped", 8'h20, 32'h0);
    wb(1'b1, TXDR_OFS_BASE_LO, 32'h0000_100f);
    wb(1'b1, TXDR_OFS_BASE_HI, 32'h0000_0001);
    wb(1'b1, TXDR_OFS_LEN, 32'h0000_0080);
    wb(1'b1, TXDR_OFS_DELAY, 32'h0000_0002);
    rd("base_hi", TXDR_OFS_BASE_HI, 32'h1);
    rd("length", TXDR_OFS_LEN, 32'h80);
    wb(1'b1, TXDR_OFS_QCTL, 32'h8000_0000);
    wb(1'b1, TXDR_OFS_HEAD, 32'h5);
    rd("head_locked", TXDR_OFS_HEAD, 32'h0);
    // immediate status writes with a slow host
    slow <= 1'b1;
    wb(1'b1, TXDR_OFS_TAIL, 32'h2);
    wait_head(32'h2);
    wait_cnt(so_n, 2);
    check("rd_first", BASE, rd_first);
    check("rd_end", BASE + 64'h20, rd_end);
    check("pkts", 64'd2, 64'(pkt_n));
    check("status_wb", 64'd2, 64'(so_n));
    check("status_addr", BASE + 64'h1c, wb_last);
    // tail at zero: run to the ring end and wrap
    slow <= 1'b0;
    wb(1'b1, TXDR_OFS_TAIL, 32'h0);
    wait_head(32'h0);
    wait_cnt(so_n, 8);
    check("wrap_status_wb", 64'd8, 64'(so_n));
    check("wrap_addr", BASE + 64'h7c, wb_last);
    // write-back threshold of two
    wb(1'b1, TXDR_OFS_QCTL, 32'h8000_0200);
    wb(1'b1, TXDR_OFS_TAIL, 32'h2);
    wait_head(32'h2);
    wait_cnt(full_n, 2);
    check("thr_full", 64'd2, 64'(full_n));
    check("thr_addr", BASE, wb_last);
    check("thr_status", 64'd8, 64'(so_n));
    check("thr_rd_end", BASE + 64'h20, rd_end);
    // delayed flush on timer expiry
    wb(1'b1, TXDR_OFS_QCTL, 32'h8000_0000);
    cmd <= 8'h89;
    e0 = ev_n;
    wb(1'b1, TXDR_OFS_TAIL, 32'h3);
    wait_head(32'h3);
    wait_cnt(full_n, 3);
    check("delay_full", 64'd3, 64'(full_n));
    check("delay_addr", BASE + 64'h20, wb_last);
    check("delay_no_status", 64'd8, 64'(so_n));
    check("delay_event", 64'd1, {63'h0, ev_n > e0});
    check("pkts_all", 64'd11, 64'(pkt_n));
    // context, then a segmented packet: prototype header buffer, payload cut at mss
    cmd <= 8'h10;
    wb(1'b1, TXDR_OFS_TAIL, 32'h4);
    wait_head(32'h4);
    cmd <= 8'h04;
    wb(1'b1, TXDR_OFS_TAIL, 32'h5);
    wait_head(32'h5);
    cmd <= 8'h05;
    wb(1'b1, TXDR_OFS_TAIL, 32'h6);
    wait_head(32'h6);
    wait_cnt(pkt_n, 12);
    check("seg_mss", 64'd4, 64'(tx_seg_mss));
    check("seg_hdr_len", 64'd8, 64'(tx_seg_hdr_len));
    check("seg_cuts", 64'd2, 64'(sb_n));
    check("seg_tse", 64'd1, 64'(tse));
    check("buf_addr", BASE + 64'h50, ba);
    summarize();
  end
endmodule
`default_nettype wire
